// ==== rtl/hw_pin_config_decoder.sv ====
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module hw_pin_config_decoder (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [1:0] mode_select,
  input wire logic [3:0] pulse_template_select,
  input wire logic equalizer_range_select,
  input wire logic receiver_power_down,
  input wire logic [1:0] transmit_pattern_select,
  input wire logic [1:0] jitter_attenuator_select,
  input wire logic monitor_gain_select,
  input wire logic [1:0] loopback_select,
  input wire logic driver_high_impedance,
  input wire logic receive_clock_edge_select,
  output logic hw_mode,
  output lineif_cfg_pkg::line_std_t line_std,
  output lineif_cfg_pkg::term_imp_t term_imp,
  output logic [3:0] pulse_template,
  output logic eq_long_haul,
  output logic rx_power_down,
  output lineif_cfg_pkg::tx_pat_t tx_pattern,
  output logic tx_power_down,
  output logic ja_enable,
  output logic ja_in_tx,
  output logic ja_narrow_bw,
  output logic ja_fifo_128,
  output logic monitor_gain_on,
  output lineif_cfg_pkg::loop_t loopback,
  output logic driver_enable,
  output logic rclk_falling,
  input wire logic [lineif_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [lineif_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  pin_sync_if ps ();
  lineif_cfg_pkg::pins_t pin_s;
  lineif_cfg_pkg::cfg_t cfg_r;
  lineif_cfg_pkg::cfg_t cfg_nxt;
  logic hold_r;
  logic [lineif_cfg_pkg::SYNC_STAGES-1:0] flush_r;
  logic sync_primed;

  assign ps.raw = '{
    receive_clock_edge_select: receive_clock_edge_select,
    driver_high_impedance: driver_high_impedance,
    loopback_select: loopback_select,
    monitor_gain_select: monitor_gain_select,
    jitter_attenuator_select: jitter_attenuator_select,
    transmit_pattern_select: transmit_pattern_select,
    receiver_power_down: receiver_power_down,
    equalizer_range_select: equalizer_range_select,
    pulse_template_select: pulse_template_select,
    mode_select: mode_select};

  pin_sync u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pins(ps.sync_side)
  );

  assign pin_s = ps.synced;

  function automatic lineif_cfg_pkg::line_std_t std_of(input logic [3:0] code);
    if (code == lineif_cfg_pkg::PULS_E1_75 || code == lineif_cfg_pkg::PULS_E1_120)
      return lineif_cfg_pkg::STD_E1;
    else if (code == lineif_cfg_pkg::PULS_J1)
      return lineif_cfg_pkg::STD_J1;
    else
      return lineif_cfg_pkg::STD_T1;
  endfunction : std_of

  function automatic lineif_cfg_pkg::term_imp_t imp_of(input logic [3:0] code);
    if (code == lineif_cfg_pkg::PULS_E1_75)
      return lineif_cfg_pkg::IMP_75;
    else if (code == lineif_cfg_pkg::PULS_E1_120)
      return lineif_cfg_pkg::IMP_120;
    else if (code == lineif_cfg_pkg::PULS_J1)
      return lineif_cfg_pkg::IMP_110;
    else
      return lineif_cfg_pkg::IMP_100;
  endfunction : imp_of

  // decode; outside hardware mode everything falls back to the safe reset set
  always_comb
  begin
    cfg_nxt = lineif_cfg_pkg::CFG_RESET;
    if (pin_s.mode_select == lineif_cfg_pkg::MODE_HW)
    begin
      cfg_nxt.hw_mode = 1'b1;
      cfg_nxt.line_std = std_of(pin_s.pulse_template_select);
      cfg_nxt.term_imp = imp_of(pin_s.pulse_template_select);
      cfg_nxt.pulse_template = pin_s.pulse_template_select;
      cfg_nxt.eq_long_haul = pin_s.equalizer_range_select;
      cfg_nxt.rx_power_down = pin_s.receiver_power_down;
      unique case (pin_s.transmit_pattern_select)
        lineif_cfg_pkg::PATT_NORMAL: cfg_nxt.tx_pattern = lineif_cfg_pkg::TXP_NORMAL;
        lineif_cfg_pkg::PATT_ALL_ONES: cfg_nxt.tx_pattern = lineif_cfg_pkg::TXP_ALL_ONES;
        lineif_cfg_pkg::PATT_PRBS: cfg_nxt.tx_pattern = lineif_cfg_pkg::TXP_PRBS;
        lineif_cfg_pkg::PATT_TX_OFF: cfg_nxt.tx_power_down = 1'b1;
      endcase
      unique case (pin_s.jitter_attenuator_select)
        lineif_cfg_pkg::JA_OFF: cfg_nxt.ja_enable = 1'b0;
        lineif_cfg_pkg::JA_RX_BROAD: cfg_nxt.ja_enable = 1'b1;
        lineif_cfg_pkg::JA_RX_NARROW, lineif_cfg_pkg::JA_TX_NARROW:
        begin
          cfg_nxt.ja_enable = 1'b1;
          cfg_nxt.ja_narrow_bw = 1'b1;
          cfg_nxt.ja_fifo_128 = 1'b1;
          cfg_nxt.ja_in_tx = (pin_s.jitter_attenuator_select
                              == lineif_cfg_pkg::JA_TX_NARROW);
        end
      endcase
      cfg_nxt.monitor_gain_on = pin_s.monitor_gain_select;
      unique case (pin_s.loopback_select)
        lineif_cfg_pkg::LP_NONE: cfg_nxt.loopback = lineif_cfg_pkg::LOOP_NONE;
        lineif_cfg_pkg::LP_ANALOG: cfg_nxt.loopback = lineif_cfg_pkg::LOOP_ANALOG;
        lineif_cfg_pkg::LP_DIGITAL: cfg_nxt.loopback = lineif_cfg_pkg::LOOP_DIGITAL;
        lineif_cfg_pkg::LP_REMOTE: cfg_nxt.loopback = lineif_cfg_pkg::LOOP_REMOTE;
      endcase
      cfg_nxt.driver_enable = !pin_s.driver_high_impedance;
      cfg_nxt.rclk_falling = pin_s.receive_clock_edge_select;
    end
  end

  // reset zeros in the synchroniser read as hardware mode with the driver on;
  // keep the reset set until real strap levels have reached the last stage
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      flush_r <= '0;
    else
      flush_r <= {flush_r[lineif_cfg_pkg::SYNC_STAGES-2:0], 1'b1};
  end

  assign sync_primed = flush_r[lineif_cfg_pkg::SYNC_STAGES-1];

  // hold lets software freeze the line setup while straps are reworked
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      cfg_r <= lineif_cfg_pkg::CFG_RESET;
    else if (!hold_r && sync_primed)
      cfg_r <= cfg_nxt;
  end

  assign hw_mode = cfg_r.hw_mode;
  assign line_std = cfg_r.line_std;
  assign term_imp = cfg_r.term_imp;
  assign pulse_template = cfg_r.pulse_template;
  assign eq_long_haul = cfg_r.eq_long_haul;
  assign rx_power_down = cfg_r.rx_power_down;
  assign tx_pattern = cfg_r.tx_pattern;
  assign tx_power_down = cfg_r.tx_power_down;
  assign ja_enable = cfg_r.ja_enable;
  assign ja_in_tx = cfg_r.ja_in_tx;
  assign ja_narrow_bw = cfg_r.ja_narrow_bw;
  assign ja_fifo_128 = cfg_r.ja_fifo_128;
  assign monitor_gain_on = cfg_r.monitor_gain_on;
  assign loopback = cfg_r.loopback;
  assign driver_enable = cfg_r.driver_enable;
  assign rclk_falling = cfg_r.rclk_falling;

  // axi4-lite write side: address and data latched independently
  logic aw_full_r;
  logic w_full_r;
  logic [lineif_cfg_pkg::ADDR_W-1:0] waddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;

  assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      aw_full_r <= 1'b0;
      waddr_r <= '0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full_r && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_axi_wready <= 1'b0;
      w_full_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else
    begin
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_full_r && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (wr_go)
        w_full_r <= 1'b0;
    end
  end

  function automatic logic addr_known(input logic [lineif_cfg_pkg::ADDR_W-1:0] a);
    return a == lineif_cfg_pkg::REG_CTRL || a == lineif_cfg_pkg::REG_PINS
        || a == lineif_cfg_pkg::REG_CONFIG;
  endfunction : addr_known

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      hold_r <= lineif_cfg_pkg::CTRL_HOLD_RESET;
    else if (wr_go && waddr_r == lineif_cfg_pkg::REG_CTRL && wstrb_r[0])
      hold_r <= wdata_r[lineif_cfg_pkg::CTRL_HOLD_BIT];
  end

  // status registers ignore writes but still answer okay
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lineif_cfg_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= addr_known(waddr_r) ? lineif_cfg_pkg::RESP_OKAY
                                         : lineif_cfg_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // axi4-lite read side
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = '0;
    if (s_axi_araddr == lineif_cfg_pkg::REG_CTRL)
      rd_word[lineif_cfg_pkg::CTRL_HOLD_BIT] = hold_r;
    else if (s_axi_araddr == lineif_cfg_pkg::REG_PINS)
      rd_word[lineif_cfg_pkg::PINS_W-1:0] = pin_s;
    else if (s_axi_araddr == lineif_cfg_pkg::REG_CONFIG)
      rd_word[lineif_cfg_pkg::CFG_W-1:0] = cfg_r;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= lineif_cfg_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= addr_known(s_axi_araddr) ? lineif_cfg_pkg::RESP_OKAY
                                                : lineif_cfg_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_live;
    !hold_r && sync_primed && pin_s.mode_select == lineif_cfg_pkg::MODE_HW;
  endsequence

  sequence s_off;
    !hold_r && sync_primed && pin_s.mode_select != lineif_cfg_pkg::MODE_HW;
  endsequence

  property p_unprimed;
    !sync_primed |=> !hw_mode && !driver_enable;
  endproperty
  a_unprimed: assert property (p_unprimed) else $error("decode before straps synced");

  property p_mode_off;
    s_off |=> !hw_mode && !driver_enable && loopback == lineif_cfg_pkg::LOOP_NONE;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("decode active outside hw mode");

  property p_std;
    s_live ##0 pin_s.pulse_template_select == lineif_cfg_pkg::PULS_E1_120
      |=> line_std == lineif_cfg_pkg::STD_E1 && term_imp == lineif_cfg_pkg::IMP_120;
  endproperty
  a_std: assert property (p_std) else $error("e1 120 ohm template misdecoded");

  property p_eq;
    s_live |=> eq_long_haul == $past(pin_s.equalizer_range_select);
  endproperty
  a_eq: assert property (p_eq) else $error("equalizer range not followed");

  property p_rpd;
    s_live |=> rx_power_down == $past(pin_s.receiver_power_down);
  endproperty
  a_rpd: assert property (p_rpd) else $error("receiver power-down not followed");

  property p_prbs;
    s_live ##0 pin_s.transmit_pattern_select == lineif_cfg_pkg::PATT_PRBS
      |=> tx_pattern == lineif_cfg_pkg::TXP_PRBS && !tx_power_down;
  endproperty
  a_prbs: assert property (p_prbs) else $error("prbs pattern not selected");

  property p_tx_off;
    s_live |=> tx_power_down == ($past(pin_s.transmit_pattern_select)
                                 == lineif_cfg_pkg::PATT_TX_OFF);
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("transmitter power-down wrong");

  property p_ja_broad;
    s_live ##0 pin_s.jitter_attenuator_select == lineif_cfg_pkg::JA_RX_BROAD
      |=> ja_enable && !ja_in_tx && !ja_narrow_bw && !ja_fifo_128;
  endproperty
  a_ja_broad: assert property (p_ja_broad) else $error("broad attenuator setup wrong");

  property p_ja_tx;
    s_live ##0 pin_s.jitter_attenuator_select == lineif_cfg_pkg::JA_TX_NARROW
      |=> ja_enable && ja_in_tx && ja_narrow_bw && ja_fifo_128;
  endproperty
  a_ja_tx: assert property (p_ja_tx) else $error("transmit attenuator setup wrong");

  property p_monitor_gain_select;
    s_live |=> monitor_gain_on == $past(pin_s.monitor_gain_select);
  endproperty
  a_monitor_gain_select: assert property (p_monitor_gain_select) else $error("monitor gain not followed");

  property p_loop;
    s_live ##0 pin_s.loopback_select == lineif_cfg_pkg::LP_REMOTE
      |=> loopback == lineif_cfg_pkg::LOOP_REMOTE;
  endproperty
  a_loop: assert property (p_loop) else $error("remote loopback not selected");

  property p_drv;
    s_live |=> driver_enable == !$past(pin_s.driver_high_impedance);
  endproperty
  a_drv: assert property (p_drv) else $error("driver enable polarity wrong");

  property p_edge;
    s_live |=> rclk_falling == $past(pin_s.receive_clock_edge_select);
  endproperty
  a_edge: assert property (p_edge) else $error("receive clock edge not followed");

  property p_sync;
    $stable(receiver_power_down)[*3] |-> pin_s.receiver_power_down == receiver_power_down;
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser latency wrong");

endmodule : hw_pin_config_decoder

// ==== shared/lineif_cfg_pkg.sv ====
package lineif_cfg_pkg;

  // axi4-lite register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PINS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h08;
  localparam logic [1:0] WORD_LSB_MASK = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CTRL_HOLD_BIT = 0;
  localparam logic CTRL_HOLD_RESET = 1'b0;

  // control interface select
  localparam logic [1:0] MODE_HW = 2'h0;

  // transmit pattern select codes
  localparam logic [1:0] PATT_NORMAL = 2'h0;
  localparam logic [1:0] PATT_ALL_ONES = 2'h1;
  localparam logic [1:0] PATT_PRBS = 2'h2;
  localparam logic [1:0] PATT_TX_OFF = 2'h3;

  // jitter attenuator select codes
  localparam logic [1:0] JA_OFF = 2'h0;
  localparam logic [1:0] JA_RX_BROAD = 2'h1;
  localparam logic [1:0] JA_RX_NARROW = 2'h2;
  localparam logic [1:0] JA_TX_NARROW = 2'h3;

  // loopback select codes
  localparam logic [1:0] LP_NONE = 2'h0;
  localparam logic [1:0] LP_ANALOG = 2'h1;
  localparam logic [1:0] LP_DIGITAL = 2'h2;
  localparam logic [1:0] LP_REMOTE = 2'h3;

  // pulse template select codes
  localparam logic [3:0] PULS_E1_75 = 4'h0;
  localparam logic [3:0] PULS_E1_120 = 4'h1;
  localparam logic [3:0] PULS_J1 = 4'h7;
  localparam logic [3:0] PULS_RESET = 4'h0;

  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {STD_E1, STD_T1, STD_J1} line_std_t;
  typedef enum logic [1:0] {IMP_75, IMP_100, IMP_110, IMP_120} term_imp_t;
  typedef enum logic [1:0] {TXP_NORMAL, TXP_ALL_ONES, TXP_PRBS} tx_pat_t;
  typedef enum logic [1:0] {LOOP_NONE, LOOP_ANALOG, LOOP_DIGITAL, LOOP_REMOTE} loop_t;

  typedef struct packed {
    logic receive_clock_edge_select;
    logic driver_high_impedance;
    logic [1:0] loopback_select;
    logic monitor_gain_select;
    logic [1:0] jitter_attenuator_select;
    logic [1:0] transmit_pattern_select;
    logic receiver_power_down;
    logic equalizer_range_select;
    logic [3:0] pulse_template_select;
    logic [1:0] mode_select;
  } pins_t;

  localparam int PINS_W = $bits(pins_t);

  typedef struct packed {
    logic rclk_falling;
    logic driver_enable;
    loop_t loopback;
    logic monitor_gain_on;
    logic ja_fifo_128;
    logic ja_narrow_bw;
    logic ja_in_tx;
    logic ja_enable;
    logic tx_power_down;
    tx_pat_t tx_pattern;
    logic rx_power_down;
    logic eq_long_haul;
    logic [3:0] pulse_template;
    term_imp_t term_imp;
    line_std_t line_std;
    logic hw_mode;
  } cfg_t;

  localparam int CFG_W = $bits(cfg_t);

  localparam cfg_t CFG_RESET = '{
    rclk_falling: 1'b0, driver_enable: 1'b0, loopback: LOOP_NONE,
    monitor_gain_on: 1'b0, ja_fifo_128: 1'b0, ja_narrow_bw: 1'b0,
    ja_in_tx: 1'b0, ja_enable: 1'b0, tx_power_down: 1'b0,
    tx_pattern: TXP_NORMAL, rx_power_down: 1'b0, eq_long_haul: 1'b0,
    pulse_template: PULS_RESET, term_imp: IMP_75, line_std: STD_E1,
    hw_mode: 1'b0};

endpackage : lineif_cfg_pkg

// ==== shared/pin_sync_if.sv ====
`timescale 1ns/10ps
interface pin_sync_if;
  lineif_cfg_pkg::pins_t raw;
  lineif_cfg_pkg::pins_t synced;
  modport sync_side (input raw, output synced);
  modport use_side (output raw, input synced);
endinterface : pin_sync_if

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  pin_sync_if.sync_side pins
);

  logic [lineif_cfg_pkg::PINS_W-1:0] raw_bus;
  logic [lineif_cfg_pkg::PINS_W-1:0] sync_bus;

  assign raw_bus = pins.raw;
  assign pins.synced = lineif_cfg_pkg::pins_t'(sync_bus);

  // two flops per strap; first stage feeds only the second
  for (genvar i = 0; i < lineif_cfg_pkg::PINS_W; i++)
  begin : g_bit
    logic meta_r;
    logic sync_r;
    always_ff @(posedge core_clk)
    begin
      if (!rst_b)
      begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
      end
      else
      begin
        meta_r <= raw_bus[i];
        sync_r <= meta_r;
      end
    end
    assign sync_bus[i] = sync_r;
  end

endmodule : pin_sync

// ==== bench/strap_source.sv ====
`timescale 1ns/10ps
// board straps: fixed levels with pull resistors, never released, so no float to model
module strap_source (
  input wire lineif_cfg_pkg::pins_t setting,
  output lineif_cfg_pkg::pins_t strap_pins
);
  // a new setting passes straight through with no clocking; the bench changes it just after a clock edge
  assign strap_pins = setting;
endmodule : strap_source

// ==== bench/hw_pin_config_decoder_tb_top.sv ====
`timescale 1ns/10ps
module hw_pin_config_decoder_tb_top;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  lineif_cfg_pkg::pins_t straps = '0;
  wire lineif_cfg_pkg::pins_t pin_w;
  wire lineif_cfg_pkg::cfg_t seen;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rd;
  lineif_cfg_pkg::cfg_t held;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [3:0] tpl [6] = '{4'h0, 4'h1, 4'h7, 4'h2, 4'h6, 4'hb};

  always #2 core_clk = ~core_clk;

  strap_source u_strap_source (.setting(straps), .strap_pins(pin_w));

  hw_pin_config_decoder u_hw_pin_config_decoder (
    .core_clk(core_clk), .rst_b(rst_b),
    .mode_select(pin_w.mode_select), .pulse_template_select(pin_w.pulse_template_select),
    .equalizer_range_select(pin_w.equalizer_range_select),
    .receiver_power_down(pin_w.receiver_power_down),
    .transmit_pattern_select(pin_w.transmit_pattern_select),
    .jitter_attenuator_select(pin_w.jitter_attenuator_select),
    .monitor_gain_select(pin_w.monitor_gain_select), .loopback_select(pin_w.loopback_select),
    .driver_high_impedance(pin_w.driver_high_impedance),
    .receive_clock_edge_select(pin_w.receive_clock_edge_select),
    .hw_mode(seen.hw_mode), .line_std(seen.line_std), .term_imp(seen.term_imp),
    .pulse_template(seen.pulse_template), .eq_long_haul(seen.eq_long_haul),
    .rx_power_down(seen.rx_power_down), .tx_pattern(seen.tx_pattern),
    .tx_power_down(seen.tx_power_down), .ja_enable(seen.ja_enable),
    .ja_in_tx(seen.ja_in_tx), .ja_narrow_bw(seen.ja_narrow_bw),
    .ja_fifo_128(seen.ja_fifo_128), .monitor_gain_on(seen.monitor_gain_on),
    .loopback(seen.loopback), .driver_enable(seen.driver_enable),
    .rclk_falling(seen.rclk_falling),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );

  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // a hung handshake would otherwise wait forever
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1 && !aw_done)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_done)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
    begin
      @(posedge core_clk);
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  function automatic lineif_cfg_pkg::pins_t mk(input int i);
    lineif_cfg_pkg::pins_t p;
    p = '0;
    p.pulse_template_select = tpl[i];
    p.equalizer_range_select = i[0];
    p.receiver_power_down = i[1];
    p.transmit_pattern_select = i[1:0];
    p.jitter_attenuator_select = i[1:0];
    p.monitor_gain_select = ~i[0];
    p.loopback_select = i[1:0];
    p.driver_high_impedance = i[1] ^ i[0];
    p.receive_clock_edge_select = i[2] | i[0];
    return p;
  endfunction : mk

  function automatic lineif_cfg_pkg::cfg_t exp_cfg(input lineif_cfg_pkg::pins_t p);
    lineif_cfg_pkg::cfg_t c;
    logic [3:0] t;
    c = lineif_cfg_pkg::CFG_RESET;
    t = p.pulse_template_select;
    if (p.mode_select == 2'h0)
    begin
      c.hw_mode = 1'b1;
      c.pulse_template = t;
      c.line_std = (t < 4'h2) ? lineif_cfg_pkg::STD_E1 :
        (t == 4'h7) ? lineif_cfg_pkg::STD_J1 : lineif_cfg_pkg::STD_T1;
      c.term_imp = (t == 4'h0) ? lineif_cfg_pkg::IMP_75 : (t == 4'h1) ? lineif_cfg_pkg::IMP_120 :
        (t == 4'h7) ? lineif_cfg_pkg::IMP_110 : lineif_cfg_pkg::IMP_100;
      c.eq_long_haul = p.equalizer_range_select;
      c.rx_power_down = p.receiver_power_down;
      c.tx_power_down = (p.transmit_pattern_select == 2'h3);
      c.tx_pattern = c.tx_power_down ? lineif_cfg_pkg::TXP_NORMAL :
        lineif_cfg_pkg::tx_pat_t'(p.transmit_pattern_select);
      c.ja_enable = |p.jitter_attenuator_select;
      c.ja_in_tx = &p.jitter_attenuator_select;
      c.ja_narrow_bw = p.jitter_attenuator_select[1];
      c.ja_fifo_128 = p.jitter_attenuator_select[1];
      c.monitor_gain_on = p.monitor_gain_select;
      c.loopback = lineif_cfg_pkg::loop_t'(p.loopback_select);
      c.driver_enable = !p.driver_high_impedance;
      c.rclk_falling = p.receive_clock_edge_select;
    end
    return c;
  endfunction : exp_cfg

  // strap change, then past the 2-flop synchroniser and decode stage
  task automatic apply(input lineif_cfg_pkg::pins_t p);
    @(posedge core_clk);
    straps <= p;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : apply

  initial
  begin
    straps = mk(0);
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1;
    check("reset outputs", 32'(lineif_cfg_pkg::CFG_RESET), 32'(seen));
    axi_read(lineif_cfg_pkg::REG_CTRL, rd, resp);
    check("ctrl reset", 32'h0, rd);
    for (int i = 0; i < 6; i++)
    begin
      apply(mk(i));
      check("decoded outputs", 32'(exp_cfg(mk(i))), 32'(seen));
      axi_read(lineif_cfg_pkg::REG_CONFIG, rd, resp);
      check("config reg", 32'(exp_cfg(mk(i))), rd);
      axi_read(lineif_cfg_pkg::REG_PINS, rd, resp);
      check("pins reg", 32'(mk(i)), rd);
    end
    for (int m = 1; m < 4; m++)
    begin
      straps.mode_select <= 2'(m);
      repeat (4) @(posedge core_clk);
      #1;
      check("non hw mode", 32'(lineif_cfg_pkg::CFG_RESET), 32'(seen));
    end
    apply(mk(1));
    @(posedge core_clk);
    straps.driver_high_impedance <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check("driver early", 32'h0, 32'(seen.driver_enable));
    @(posedge core_clk);
    #1;
    check("driver on", 32'h1, 32'(seen.driver_enable));
    held = seen;
    axi_write(lineif_cfg_pkg::REG_CTRL, 32'h1, resp);
    check("ctrl bresp", 32'(lineif_cfg_pkg::RESP_OKAY), 32'(resp));
    axi_read(lineif_cfg_pkg::REG_CTRL, rd, resp);
    check("ctrl hold", 32'h1, rd);
    apply(mk(2));
    repeat (2) @(posedge core_clk);
    #1;
    check("frozen outputs", 32'(held), 32'(seen));
    axi_write(lineif_cfg_pkg::REG_CONFIG, 32'hffff_ffff, resp);
    check("ro bresp", 32'(lineif_cfg_pkg::RESP_OKAY), 32'(resp));
    axi_write(lineif_cfg_pkg::REG_CTRL, 32'h0, resp);
    repeat (4) @(posedge core_clk);
    #1;
    check("released outputs", 32'(exp_cfg(mk(2))), 32'(seen));
    axi_read(8'h0c, rd, resp);
    check("unmapped rresp", 32'(lineif_cfg_pkg::RESP_SLVERR), 32'(resp));
    check("unmapped rdata", 32'h0, rd);
    tally_and_finish();
  end
endmodule : hw_pin_config_decoder_tb_top
